// ==== verilog/port_override_ctl.sv ====
/*
 AXI4-Lite slave driving the override sources.
 Assumes one clock and a well-behaved master.
*/
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module port_override_ctl (
    input  wire logic                           sys_clk,
    input  wire logic                           resetn,
    pin_mux_if.periph                           link,
    input  wire logic [pin_mux_pkg::CTL_AW-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic      [1:0]                     s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [pin_mux_pkg::CTL_AW-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic      [31:0]                    s_axi_rdata,
    output logic      [1:0]                     s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready
);
    import pin_mux_pkg::*;

    logic              aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [CTL_AW-1:0] aw_addr_r, aw_addr_nxt;
    logic [31:0]       w_data_r, w_data_nxt, wr_val;
    logic [3:0]        w_strb_r, w_strb_nxt;
    logic              awready_r, awready_nxt, wready_r, wready_nxt;
    logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [ALT_W-1:0]  alt_r, alt_nxt;
    logic [7:0]        pcmask_r, pcmask_nxt;
    logic [DEV_AW-1:0] dev_addr_r, dev_addr_nxt;
    logic [7:0]        dev_data_r, dev_data_nxt;
    logic              dev_wr_r, dev_wr_nxt;
    logic              do_wr;

    // Byte lanes merge into the old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    assign do_wr  = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_val = w_data_r;

    always_comb begin
        aw_have_nxt  = aw_have_r;
        aw_addr_nxt  = aw_addr_r;
        w_have_nxt   = w_have_r;
        w_data_nxt   = w_data_r;
        w_strb_nxt   = w_strb_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        ctrl_nxt     = ctrl_r;
        alt_nxt      = alt_r;
        pcmask_nxt   = pcmask_r;
        dev_addr_nxt = dev_addr_r;
        dev_data_nxt = dev_data_r;
        dev_wr_nxt   = 1'b0;
        if (s_axi_awvalid && awready_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_wr) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = RESP_OKAY;
            case (aw_addr_r)
                // Port still needs its dir bit
                CREG_CTRL:   ctrl_nxt   = CTRL_W'(merge(32'(ctrl_r), wr_val, w_strb_r));
                CREG_ALT:    alt_nxt    = ALT_W'(merge(32'(alt_r), wr_val, w_strb_r));
                CREG_PCMASK: pcmask_nxt = 8'(merge(32'(pcmask_r), wr_val, w_strb_r));
                CREG_DEVACC: begin
                    dev_addr_nxt = wr_val[DEV_AW-1:0];
                    dev_data_nxt = wr_val[ACC_DATA_LSB +: 8];
                    dev_wr_nxt   = w_strb_r[1];
                end
                CREG_STATUS: ;
                default:     bresp_nxt = RESP_SLVERR;
            endcase
        end
        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
    end

    // One read in flight, answer next cycle
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            case (s_axi_araddr)
                CREG_CTRL:   rdata_nxt = 32'(ctrl_r);
                CREG_ALT:    rdata_nxt = 32'(alt_r);
                CREG_PCMASK: rdata_nxt = 32'(pcmask_r);
                CREG_DEVACC: rdata_nxt = {16'h0000, link.reg_rdata, 5'h00, dev_addr_r};
                CREG_STATUS: rdata_nxt = {24'h00_0000, link.pin_change_src};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            aw_have_r  <= 1'b0;
            aw_addr_r  <= '0;
            w_have_r   <= 1'b0;
            w_data_r   <= 32'h0000_0000;
            w_strb_r   <= 4'h0;
            awready_r  <= 1'b1;
            wready_r   <= 1'b1;
            bvalid_r   <= 1'b0;
            bresp_r    <= RESP_OKAY;
            arready_r  <= 1'b1;
            rvalid_r   <= 1'b0;
            rresp_r    <= RESP_OKAY;
            rdata_r    <= 32'h0000_0000;
            ctrl_r     <= '0;
            alt_r      <= '0;
            pcmask_r   <= 8'h00;
            dev_addr_r <= '0;
            dev_data_r <= 8'h00;
            dev_wr_r   <= 1'b0;
        end else begin
            aw_have_r  <= aw_have_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_have_r   <= w_have_nxt;
            w_data_r   <= w_data_nxt;
            w_strb_r   <= w_strb_nxt;
            awready_r  <= awready_nxt;
            wready_r   <= wready_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            arready_r  <= arready_nxt;
            rvalid_r   <= rvalid_nxt;
            rresp_r    <= rresp_nxt;
            rdata_r    <= rdata_nxt;
            ctrl_r     <= ctrl_nxt;
            alt_r      <= alt_nxt;
            pcmask_r   <= pcmask_nxt;
            dev_addr_r <= dev_addr_nxt;
            dev_data_r <= dev_data_nxt;
            dev_wr_r   <= dev_wr_nxt;
        end
    end

    assign s_axi_awready       = awready_r;
    assign s_axi_wready        = wready_r;
    assign s_axi_bvalid        = bvalid_r;
    assign s_axi_bresp         = bresp_r;
    assign s_axi_arready       = arready_r;
    assign s_axi_rvalid        = rvalid_r;
    assign s_axi_rresp         = rresp_r;
    assign s_axi_rdata         = rdata_r;
    assign link.reg_wr         = dev_wr_r;
    assign link.reg_addr       = dev_addr_r;
    assign link.reg_wdata      = dev_data_r;
    assign link.lcd_drive_on   = ctrl_r[CTRL_LCD_BIT];
    assign link.lcd_duty_sel   = ctrl_r[CTRL_DUTY_LSB +: 2];
    assign link.spi_en         = ctrl_r[CTRL_SPE_BIT];
    assign link.spi_master     = ctrl_r[CTRL_MSTR_BIT];
    assign link.pcint_group_en = ctrl_r[CTRL_PCGRP_BIT];
    assign link.t_cmp_en       = alt_r[ALT_TEN_LSB +: 4];
    assign link.t_cmp_val      = alt_r[ALT_TVAL_LSB +: 4];
    assign link.spi_miso_out   = alt_r[ALT_MISO_BIT];
    assign link.spi_mosi_out   = alt_r[ALT_MOSI_BIT];
    assign link.spi_sck_out    = alt_r[ALT_SCK_BIT];
    assign link.pcint_en       = pcmask_r;

endmodule // port_override_ctl

// ==== verilog/pin_mux_pkg.sv ====
/*
 Shared constants: register indices, fields, resets.
 Assumes one clock and 32-bit AXI4-Lite.
*/
package pin_mux_pkg;
    localparam int          PINS           = 8;
    localparam int          DEV_AW         = 3;
    // Device registers on the link, by index
    localparam logic [2:0]  DREG_MCU       = 3'h0;
    localparam logic [2:0]  DREG_DIR_A     = 3'h1;
    localparam logic [2:0]  DREG_OUT_A     = 3'h2;
    localparam logic [2:0]  DREG_DIR_B     = 3'h3;
    localparam logic [2:0]  DREG_OUT_B     = 3'h4;
    localparam logic [7:0]  MCU_RESET      = 8'h00;
    localparam logic [7:0]  MCU_WMASK      = 8'h93;
    localparam int          MCU_KILL_BIT   = 4;
    localparam logic [7:0]  PORT_RESET     = 8'h00;
    // Controller registers, byte addresses
    localparam int          CTL_AW         = 8;
    localparam logic [7:0]  CREG_CTRL      = 8'h00;
    localparam logic [7:0]  CREG_ALT       = 8'h04;
    localparam logic [7:0]  CREG_PCMASK    = 8'h08;
    localparam logic [7:0]  CREG_DEVACC    = 8'h0C;
    localparam logic [7:0]  CREG_STATUS    = 8'h10;
    localparam int          CTRL_LCD_BIT   = 0;
    localparam int          CTRL_DUTY_LSB  = 1;
    localparam int          CTRL_SPE_BIT   = 3;
    localparam int          CTRL_MSTR_BIT  = 4;
    localparam int          CTRL_PCGRP_BIT = 5;
    localparam int          CTRL_W         = 6;
    localparam int          ALT_TEN_LSB    = 0;
    localparam int          ALT_TVAL_LSB   = 4;
    localparam int          ALT_MISO_BIT   = 8;
    localparam int          ALT_MOSI_BIT   = 9;
    localparam int          ALT_SCK_BIT    = 10;
    localparam int          ALT_W          = 11;
    localparam int          ACC_DATA_LSB   = 8;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage

// ==== verilog/pin_mux_if.sv ====
/*
 Link between the two ends.
 One shared clock, no synchronisation.
*/
`timescale 1ns/1ps
interface pin_mux_if;
    logic                           reg_wr;
    logic [pin_mux_pkg::DEV_AW-1:0] reg_addr;
    logic [7:0]                     reg_wdata;
    logic [7:0]                     reg_rdata;
    logic                           lcd_drive_on;
    logic [1:0]                     lcd_duty_sel;
    logic [3:0]                     t_cmp_en;
    logic [3:0]                     t_cmp_val;
    logic                           spi_en;
    logic                           spi_master;
    logic                           spi_miso_out;
    logic                           spi_mosi_out;
    logic                           spi_sck_out;
    logic [7:0]                     pcint_en;
    logic                           pcint_group_en;
    logic [7:0]                     pin_change_src;

    modport device (
        input  reg_wr, reg_addr, reg_wdata, lcd_drive_on, lcd_duty_sel, t_cmp_en, t_cmp_val,
               spi_en, spi_master, spi_miso_out, spi_mosi_out, spi_sck_out, pcint_en, pcint_group_en,
        output reg_rdata, pin_change_src
    );
    modport periph (
        output reg_wr, reg_addr, reg_wdata, lcd_drive_on, lcd_duty_sel, t_cmp_en, t_cmp_val,
               spi_en, spi_master, spi_miso_out, spi_mosi_out, spi_sck_out, pcint_en, pcint_group_en,
        input  reg_rdata, pin_change_src
    );
endinterface

// ==== verilog/port_override_dev.sv ====
/*
 Override logic for two 8-bit ports.
 Holds the port registers, resolves each pad.
 Assumes overrides on the same clock.
 Pad cells act on the enables.
*/
`timescale 1ns/1ps
// Operation
// - Pull-up kill turns every pull-up off
// - Port A: front planes high, back planes low
// - LCD front-plane pins: no pull-up, driver, input
// - Back-plane pins overridden by duty select
// - B7 timer2 compare A, needs dir bit
// - B6 timer1 compare B, needs dir bit
// - B5 timer1 compare A, needs dir bit
// - B4 timer0 compare A, needs dir bit
// - Port B pads feed pin-change sources
// - B3..B0 are MISO, MOSI, SCK, select
// - Master forces MISO to input
// - Forced inputs keep out-bit pull-up control
// - Slave forces MOSI to input
// - Slave forces SCK to input
// - Default pull-up only for dir0 out1 kill0
// - Direction override drives the output enable
// - Value override replaces the out bit while output enabled
// - Input-enable override beats sleep clamping
module port_override_dev (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    pin_mux_if.device       link,
    input  wire logic       sleep,
    input  wire logic [7:0] pad_b_i,
    output logic      [7:0] pad_a_o,
    output logic      [7:0] pad_a_oe,
    output logic      [7:0] pad_a_pu,
    output logic      [7:0] pad_a_ie,
    output logic      [7:0] pad_a_lcd_conn,
    output logic      [7:0] pad_b_o,
    output logic      [7:0] pad_b_oe,
    output logic      [7:0] pad_b_pu,
    output logic      [7:0] pad_b_ie
);
    import pin_mux_pkg::*;

    logic [7:0]  mcu_control_r, mcu_control_nxt;
    logic [7:0]  dir_a_r, dir_a_nxt;
    logic [7:0]  out_a_r, out_a_nxt;
    logic [7:0]  dir_b_r, dir_b_nxt;
    logic [7:0]  out_b_r, out_b_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic [15:0] pu_r, pu_nxt;
    logic [15:0] oe_r, oe_nxt;
    logic [15:0] val_r, val_nxt;
    logic [15:0] ie_r, ie_nxt;
    logic [7:0]  lcd_conn_r, lcd_conn_nxt;
    logic [7:0]  sync1_r, sync2_r;
    logic [7:0]  pin_change_r;
    logic [15:0] dir_bit, out_bit;
    logic [15:0] pullup_ovr_en, pullup_ovr_val;
    logic [15:0] dir_ovr_en, dir_ovr_val;
    logic [15:0] value_ovr_en, value_ovr_val;
    logic [15:0] input_en_ovr_en, input_en_ovr_val;
    logic        pullup_kill;
    logic        spi_mst, spi_slv;

    // Register file, written over the link
    always_comb begin
        mcu_control_nxt = mcu_control_r;
        dir_a_nxt       = dir_a_r;
        out_a_nxt       = out_a_r;
        dir_b_nxt       = dir_b_r;
        out_b_nxt       = out_b_r;
        if (link.reg_wr) begin
            case (link.reg_addr)
                DREG_MCU:   mcu_control_nxt = link.reg_wdata & MCU_WMASK;
                DREG_DIR_A: dir_a_nxt = link.reg_wdata;
                DREG_OUT_A: out_a_nxt = link.reg_wdata;
                DREG_DIR_B: dir_b_nxt = link.reg_wdata;
                DREG_OUT_B: out_b_nxt = link.reg_wdata;
                default:    ;
            endcase
        end
        case (link.reg_addr)
            DREG_MCU:   rdata_nxt = mcu_control_r;
            DREG_DIR_A: rdata_nxt = dir_a_r;
            DREG_OUT_A: rdata_nxt = out_a_r;
            DREG_DIR_B: rdata_nxt = dir_b_r;
            DREG_OUT_B: rdata_nxt = out_b_r;
            default:    rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mcu_control_r <= MCU_RESET;
            dir_a_r       <= PORT_RESET;
            out_a_r       <= PORT_RESET;
            dir_b_r       <= PORT_RESET;
            out_b_r       <= PORT_RESET;
            rdata_r       <= 8'h00;
        end else begin
            mcu_control_r <= mcu_control_nxt;
            dir_a_r       <= dir_a_nxt;
            out_a_r       <= out_a_nxt;
            dir_b_r       <= dir_b_nxt;
            out_b_r       <= out_b_nxt;
            rdata_r       <= rdata_nxt;
        end
    end

    // Next values, so a write shows at once
    assign dir_bit     = {dir_b_nxt, dir_a_nxt};
    assign out_bit     = {out_b_nxt, out_a_nxt};
    assign pullup_kill = mcu_control_nxt[MCU_KILL_BIT];
    assign spi_mst     = link.spi_en & link.spi_master;
    assign spi_slv     = link.spi_en & ~link.spi_master;

    // Override sources per pin; index 0..7 port A, 8..15 port B
    always_comb begin
        pullup_ovr_en    = 16'h0000;
        pullup_ovr_val   = 16'h0000;
        dir_ovr_en       = 16'h0000;
        dir_ovr_val      = 16'h0000;
        value_ovr_en     = 16'h0000;
        value_ovr_val    = 16'h0000;
        input_en_ovr_en  = 16'h0000;
        input_en_ovr_val = 16'h0000;
        for (int i = 0; i < PINS; i++) begin
            // Front planes on 7..4 always, back planes on 3..0 by duty
            if (i >= 4 || link.lcd_duty_sel >= 2'(i)) begin
                pullup_ovr_en[i]   = link.lcd_drive_on;
                dir_ovr_en[i]      = link.lcd_drive_on;
                input_en_ovr_en[i] = link.lcd_drive_on;
            end
            // Pin change keeps input alive in sleep
            input_en_ovr_en[PINS+i]  = link.pcint_en[i] & link.pcint_group_en;
            input_en_ovr_val[PINS+i] = 1'b1;
        end
        // Dir bit still gates the compare outputs
        value_ovr_en[15:12]  = link.t_cmp_en;
        value_ovr_val[15:12] = link.t_cmp_val;
        // Port B 3..0 serial pins
        dir_ovr_en[11]     = spi_mst;
        dir_ovr_en[10]     = spi_slv;
        dir_ovr_en[9]      = spi_slv;
        dir_ovr_en[8]      = spi_slv;
        pullup_ovr_en[11:8]  = dir_ovr_en[11:8];
        pullup_ovr_val[11:8] = out_b_nxt[3:0] & {4{~pullup_kill}};
        value_ovr_en[11]   = spi_slv;
        value_ovr_val[11]  = link.spi_miso_out;
        value_ovr_en[10]   = spi_mst;
        value_ovr_val[10]  = link.spi_mosi_out;
        value_ovr_en[9]    = spi_mst;
        value_ovr_val[9]   = link.spi_sck_out;
    end

    for (genvar g = 0; g < 2*PINS; g++) begin : g_pin
        assign pu_nxt[g]  = pullup_ovr_en[g] ? pullup_ovr_val[g]
                          : (~dir_bit[g] & out_bit[g] & ~pullup_kill);
        assign oe_nxt[g]  = dir_ovr_en[g] ? dir_ovr_val[g] : dir_bit[g];
        assign val_nxt[g] = (oe_nxt[g] & value_ovr_en[g]) ? value_ovr_val[g]
                          : out_bit[g];
        assign ie_nxt[g]  = input_en_ovr_en[g] ? input_en_ovr_val[g] : ~sleep;
    end

    // Analog path only while handed to display
    assign lcd_conn_nxt = dir_ovr_en[7:0];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pu_r       <= 16'h0000;
            oe_r       <= 16'h0000;
            val_r      <= 16'h0000;
            ie_r       <= 16'h0000;
            lcd_conn_r <= 8'h00;
        end else begin
            pu_r       <= pu_nxt;
            oe_r       <= oe_nxt;
            val_r      <= val_nxt;
            ie_r       <= ie_nxt;
            lcd_conn_r <= lcd_conn_nxt;
        end
    end

    // Async pads; two-flop sync
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sync1_r      <= 8'h00;
            sync2_r      <= 8'h00;
            pin_change_r <= 8'h00;
        end else begin
            sync1_r      <= pad_b_i;
            sync2_r      <= sync1_r;
            pin_change_r <= sync2_r & ie_r[15:8];
        end
    end

    assign link.reg_rdata      = rdata_r;
    assign link.pin_change_src = pin_change_r;
    assign pad_a_o        = val_r[7:0];
    assign pad_a_oe       = oe_r[7:0];
    assign pad_a_pu       = pu_r[7:0];
    assign pad_a_ie       = ie_r[7:0];
    assign pad_a_lcd_conn = lcd_conn_r;
    assign pad_b_o        = val_r[15:8];
    assign pad_b_oe       = oe_r[15:8];
    assign pad_b_pu       = pu_r[15:8];
    assign pad_b_ie       = ie_r[15:8];

endmodule // port_override_dev

// ==== sim/port_override_checker.sv ====
/*
 Assertions on the link and pads.
 Assumes one clock.
*/
`timescale 1ns/1ps
module port_override_checker (
    input wire logic                           sys_clk,
    input wire logic                           resetn,
    input wire logic                           reg_wr,
    input wire logic [pin_mux_pkg::DEV_AW-1:0] reg_addr,
    input wire logic [7:0]                     reg_wdata,
    input wire logic                           lcd_drive_on,
    input wire logic [1:0]                     lcd_duty_sel,
    input wire logic [3:0]                     t_cmp_en,
    input wire logic [3:0]                     t_cmp_val,
    input wire logic                           spi_en,
    input wire logic                           spi_master,
    input wire logic [7:0]                     pcint_en,
    input wire logic                           pcint_group_en,
    input wire logic [7:0]                     pin_change_src,
    input wire logic [7:0]                     pad_b_i,
    input wire logic [7:0]                     pad_a_oe,
    input wire logic [7:0]                     pad_a_lcd_conn,
    input wire logic [7:0]                     pad_b_o,
    input wire logic [7:0]                     pad_b_oe,
    input wire logic [7:0]                     pad_b_pu
);
    import pin_mux_pkg::*;
    // Shadow of device bits from link writes
    logic       kill_r, kill_nxt;
    logic [7:0] dir_b_r, dir_b_nxt;
    always_comb begin
        kill_nxt = kill_r;
        dir_b_nxt = dir_b_r;
        if (reg_wr && reg_addr == DREG_MCU) kill_nxt = reg_wdata[MCU_KILL_BIT];
        if (reg_wr && reg_addr == DREG_DIR_B) dir_b_nxt = reg_wdata;
    end
    always_ff @(posedge sys_clk) begin
        kill_r <= resetn ? kill_nxt : 1'b0;
        dir_b_r <= resetn ? dir_b_nxt : 8'h00;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_pc_on; pcint_group_en && pcint_en == 8'hFF; endsequence
    property p_front; lcd_drive_on |=> pad_a_oe[7:4] == 4'h0 && pad_a_lcd_conn[7:4] == 4'hF; endproperty
    a_front: assert property (p_front) else $error("front pins not handed over");
    property p_back; lcd_drive_on |=> pad_a_lcd_conn[3:0] == 4'hF >> (2'd3 - $past(lcd_duty_sel)); endproperty
    a_back: assert property (p_back) else $error("back pins wrong for duty");
    property p_kill; kill_r |-> pad_b_pu == 8'h00; endproperty
    a_kill: assert property (p_kill) else $error("pull-up on while killed");
    property p_dir; pad_b_oe[7:4] == dir_b_r[7:4]; endproperty
    a_dir: assert property (p_dir) else $error("timer pin driver not dir bit");
    property p_tmr; $past(t_cmp_en[0]) && dir_b_r[4] |-> pad_b_o[4] == $past(t_cmp_val[0]); endproperty
    a_tmr: assert property (p_tmr) else $error("compare value missing");
    property p_mst; spi_en && spi_master |=> !pad_b_oe[3]; endproperty
    a_mst: assert property (p_mst) else $error("master input pin driven");
    property p_slv; spi_en && !spi_master |=> pad_b_oe[2:0] == 3'h0; endproperty
    a_slv: assert property (p_slv) else $error("slave input pins driven");
    property p_pc; s_pc_on[*4] |-> pin_change_src == $past(pad_b_i, 3); endproperty
    a_pc: assert property (p_pc) else $error("pin change source lags pad");
    property p_wr; reg_wr |=> !reg_wr; endproperty
    a_wr: assert property (p_wr) else $error("register write not a pulse");
endmodule // port_override_checker

// ==== sim/port_alt_function_override_tb_top.sv ====
/*
 Bench: both ends driven over AXI4-Lite.
 Assumes the controller map.
*/
`timescale 1ns/1ps
module port_alt_function_override_tb_top;
    import pin_mux_pkg::*;
    logic        sys_clk = 1'b0, resetn = 1'b0, sleep = 1'b0;
    logic [7:0]  pad_b_i = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0]  pad_a_o, pad_a_oe, pad_a_pu, pad_a_ie, pad_a_lcd_conn, pad_b_o, pad_b_oe, pad_b_pu, pad_b_ie;
    int          fails = 0, num_checks = 0, cycles = 0;
    pin_mux_if link();
    port_override_dev u_port_override_dev (.sys_clk, .resetn, .link, .sleep, .pad_b_i, .pad_a_o, .pad_a_oe,
        .pad_a_pu, .pad_a_ie, .pad_a_lcd_conn, .pad_b_o, .pad_b_oe, .pad_b_pu, .pad_b_ie);
    port_override_ctl u_port_override_ctl (.sys_clk, .resetn, .link, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    port_override_checker u_port_override_checker (.sys_clk, .resetn, .reg_wr(link.reg_wr),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .lcd_drive_on(link.lcd_drive_on),
        .lcd_duty_sel(link.lcd_duty_sel), .t_cmp_en(link.t_cmp_en), .t_cmp_val(link.t_cmp_val),
        .spi_en(link.spi_en), .spi_master(link.spi_master), .pcint_en(link.pcint_en),
        .pcint_group_en(link.pcint_group_en), .pin_change_src(link.pin_change_src), .pad_b_i, .pad_a_oe,
        .pad_a_lcd_conn, .pad_b_o, .pad_b_oe, .pad_b_pu);
    always #25 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, RESP_OKAY);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", s_axi_rresp, r);
    endtask
    task automatic dev_wr(input logic [2:0] i, input logic [7:0] d);
        axi_wr(CREG_DEVACC, {16'h0000, d, 5'h00, i}, 4'h3);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Run needs about 130 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            print_verdict;
        end
    end
    initial begin
        logic [3:0] m;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        dev_wr(DREG_DIR_B, 8'hF0);
        dev_wr(DREG_OUT_B, 8'h0F);
        settle;
        chk("b_oe", pad_b_oe, 8'hF0);
        chk("b_pu", pad_b_pu, 8'h0F);
        dev_wr(DREG_MCU, 8'hFF);
        axi_wr(CREG_DEVACC, 32'h0000_0000, 4'h1);
        axi_rd(CREG_DEVACC, 32'h0000_9300, RESP_OKAY);
        chk("b_pu", pad_b_pu, 8'h00);
        dev_wr(DREG_MCU, 8'h00);
        axi_wr(CREG_ALT, 32'h0000_005F, 4'hF);
        settle;
        chk("b_o", pad_b_o[7:4], 4'h5);
        dev_wr(DREG_DIR_B, 8'h0F);
        settle;
        chk("b_oe", pad_b_oe, 8'h0F);
        chk("b_o", pad_b_o[7:4], 4'h0);
        dev_wr(DREG_DIR_B, 8'hFF);
        axi_wr(CREG_CTRL, 32'h0000_0018, 4'hF);
        settle;
        chk("b_oe", pad_b_oe, 8'hF7);
        chk("b_pu", pad_b_pu, 8'h08);
        chk("b_o", pad_b_o, 8'h59);
        axi_wr(CREG_CTRL, 32'h0000_0008, 4'hF);
        settle;
        chk("b_oe", pad_b_oe, 8'hF8);
        chk("b_pu", pad_b_pu, 8'h07);
        chk("b_o", pad_b_o, 8'h57);
        dev_wr(DREG_DIR_A, 8'h0F);
        dev_wr(DREG_OUT_A, 8'hF0);
        for (int d = 0; d < 4; d++) begin
            axi_wr(CREG_CTRL, 32'(1 + 2 * d), 4'hF);
            settle;
            m = 4'hF >> (3 - d);
            chk("a_oe", pad_a_oe, {4'h0, ~m});
            chk("a_lcd", pad_a_lcd_conn, {4'hF, m});
            chk("a_pu", pad_a_pu, 8'h00);
            chk("a_ie", pad_a_ie, {4'h0, ~m});
            chk("a_o", pad_a_o, 8'hF0);
        end
        axi_wr(CREG_PCMASK, 32'h0000_00FF, 4'hF);
        axi_wr(CREG_CTRL, 32'h0000_0020, 4'hF);
        sleep <= 1'b1;
        pad_b_i <= 8'hA5;
        settle;
        chk("b_ie", pad_b_ie, 8'hFF);
        axi_rd(CREG_STATUS, 32'h0000_00A5, RESP_OKAY);
        axi_rd(8'h14, 32'h0000_0000, RESP_SLVERR);
        print_verdict;
    end
endmodule // port_alt_function_override_tb_top
